// *** hdl/uic_channel.sv ***
module uic_channel #(
  parameter int W = 16,
  parameter bit HAS_FREQ = 1'b0,
  parameter int FREQ_SHORT_CYC = uic_pkg::GATE_SHORT_CYC,
  parameter int FREQ_MID_CYC = uic_pkg::GATE_MID_CYC,
  parameter int FREQ_LONG_CYC = uic_pkg::GATE_LONG_CYC,
  parameter int TICK_CYC = uic_pkg::PERIOD_TICK_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic running,
  input wire logic apply,
  input wire logic lvl,
  input wire logic [7:0] cfg,
  input wire logic cnt_en,
  input wire logic load,
  input wire logic [W-1:0] cmp_val,
  output logic [W-1:0] value,
  output logic irq
);
  typedef struct packed {
    logic prev;
    logic [W-1:0] cnt;
    logic [W-1:0] cmp;
    logic [W-1:0] value;
    logic irq;
    uic_pkg::uic_gate_state_type gs;
    logic [31:0] timer;
    logic [15:0] tick;
    logic armed;
  } uic_chan_st_type;

  localparam logic [31:0] LIM_SHORT = 32'(FREQ_SHORT_CYC - 1);
  localparam logic [31:0] LIM_MID = 32'(FREQ_MID_CYC - 1);
  localparam logic [31:0] LIM_LONG = 32'(FREQ_LONG_CYC - 1);
  localparam logic [15:0] LIM_TICK = 16'(TICK_CYC - 1);

  uic_chan_st_type s_q, s_d;
  uic_pkg::uic_mode_type mode;
  logic rise, fall, ev, down, ien;
  logic [W-1:0] ones;

  // types that this input cannot do fall back to plain input
  function automatic uic_pkg::uic_mode_type eff_mode(input logic [7:0] c);
    uic_pkg::uic_mode_type m;
    m = uic_pkg::uic_mode_type'(c[uic_pkg::CFG_MODE_LSB +: 3]);
    case (m)
      uic_pkg::MODE_IRQ, uic_pkg::MODE_COUNT, uic_pkg::MODE_GATE: eff_mode = m;
      uic_pkg::MODE_FREQ, uic_pkg::MODE_PERIOD: eff_mode = HAS_FREQ ? m : uic_pkg::MODE_PLAIN;
      default: eff_mode = uic_pkg::MODE_PLAIN;
    endcase
  endfunction : eff_mode

  function automatic logic [31:0] gate_limit(input logic [1:0] g);
    case (uic_pkg::uic_gsel_type'(g))
      uic_pkg::GSEL_SHORT: gate_limit = LIM_SHORT;
      uic_pkg::GSEL_LONG: gate_limit = LIM_LONG;
      default: gate_limit = LIM_MID;
    endcase
  endfunction : gate_limit

  assign mode = eff_mode(cfg);
  assign down = cfg[uic_pkg::CFG_DIR_BIT];
  assign ien = cfg[uic_pkg::CFG_IRQ_BIT];
  assign ones = '1;
  assign rise = lvl & ~s_q.prev;
  assign fall = ~lvl & s_q.prev;
  assign ev = cfg[uic_pkg::CFG_FALL_BIT] ? fall : rise;

  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;
    s_d.prev = lvl;
    if (load) begin
      s_d.cmp = cmp_val;
    end
    if (apply) begin
      // fresh start with the newly applied parameter set
      s_d.cnt = down ? s_q.cmp : '0;
      s_d.value = (mode == uic_pkg::MODE_COUNT) ? s_d.cnt : ones;
      s_d.gs = uic_pkg::GS_IDLE;
      s_d.timer = '0;
      s_d.tick = '0;
      s_d.armed = 1'b0;
    end else if (running) begin
      case (mode)
        uic_pkg::MODE_IRQ: begin
          s_d.irq = ev;
        end
        uic_pkg::MODE_COUNT: begin
          if (load && down) begin
            s_d.cnt = cmp_val;
          end else if (cnt_en && ev) begin
            if (down) begin
              s_d.cnt = s_q.cnt - 1'b1;
              s_d.irq = ien && (s_q.cnt == '0);
            end else begin
              s_d.cnt = s_q.cnt + 1'b1;
              s_d.irq = ien && ((s_q.cnt + 1'b1) == s_q.cmp);
            end
          end
          s_d.value = s_d.cnt;
        end
        uic_pkg::MODE_GATE: begin
          case (s_q.gs)
            uic_pkg::GS_IDLE: begin
              if (rise && cnt_en) begin
                s_d.cnt = '0;
                s_d.gs = uic_pkg::GS_MEAS;
              end
            end
            uic_pkg::GS_MEAS: begin
              if (fall) begin
                s_d.value = s_q.cnt;
                s_d.irq = ien;
                s_d.gs = uic_pkg::GS_IDLE;
              end else if (s_q.cnt != ones) begin
                s_d.cnt = s_q.cnt + 1'b1;
              end
            end
            default: begin
              s_d.gs = uic_pkg::GS_IDLE;
            end
          endcase
        end
        uic_pkg::MODE_FREQ: begin
          if (ev && s_q.cnt != ones) begin
            s_d.cnt = s_q.cnt + 1'b1;
          end
          if (s_q.timer >= gate_limit(cfg[uic_pkg::CFG_GSEL_LSB +: 2])) begin
            s_d.value = s_d.cnt;
            s_d.cnt = '0;
            s_d.timer = '0;
          end else begin
            s_d.timer = s_q.timer + 1'b1;
          end
        end
        uic_pkg::MODE_PERIOD: begin
          if (rise) begin
            if (s_q.armed) begin
              s_d.value = s_q.cnt;
            end
            s_d.cnt = '0;
            s_d.tick = '0;
            s_d.armed = 1'b1;
          end else if (s_q.tick == LIM_TICK) begin
            s_d.tick = '0;
            if (s_q.cnt != ones) begin
              s_d.cnt = s_q.cnt + 1'b1;
            end
          end else begin
            s_d.tick = s_q.tick + 1'b1;
          end
        end
        default: begin
          s_d.cnt = s_q.cnt;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.gs <= uic_pkg::GS_IDLE;
      s_q.value <= '1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign value = s_q.value;
  assign irq = s_q.irq;

  ////////////////////////////////////////////////////////////////////////////
  AST_IRQ_PULSE: assert property (@(posedge clk) disable iff (rst)
    (ce && s_q.irq) |=> !s_q.irq) else $error("interrupt longer than one cycle");
  AST_UP_STEP: assert property (@(posedge clk) disable iff (rst)
    (ce && running && !apply && !load && mode == uic_pkg::MODE_COUNT && cnt_en && ev && !down)
    |=> s_q.cnt == $past(s_q.cnt) + 1'b1) else $error("up count did not step by one");
  AST_DOWN_STEP: assert property (@(posedge clk) disable iff (rst)
    (ce && running && !apply && !load && mode == uic_pkg::MODE_COUNT && cnt_en && ev && down)
    |=> s_q.cnt == $past(s_q.cnt) - 1'b1) else $error("down count did not step by one");
  AST_NO_EDGE_HOLD: assert property (@(posedge clk) disable iff (rst)
    (ce && !apply && !load && mode == uic_pkg::MODE_COUNT && !ev)
    |=> $stable(s_q.cnt)) else $error("count moved without selected edge");
  AST_LOAD_HOLD: assert property (@(posedge clk) disable iff (rst)
    (!load) |=> $stable(s_q.cmp)) else $error("comparison value changed without load");
  AST_GATE_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (ce && running && !apply && mode == uic_pkg::MODE_GATE && s_q.gs == uic_pkg::GS_IDLE
     && rise && cnt_en) |=> (s_q.cnt == '0 && s_q.gs == uic_pkg::GS_MEAS))
    else $error("gate rise did not clear and start");
  AST_INVALID_ONES: assert property (@(posedge clk) disable iff (rst)
    (ce && apply && mode != uic_pkg::MODE_COUNT) |=> s_q.value == ones)
    else $error("no all-ones result after apply");
  AST_DOWN_ZERO_IRQ: assert property (@(posedge clk) disable iff (rst)
    (ce && running && !apply && !load && mode == uic_pkg::MODE_COUNT && cnt_en && ev && down
     && ien && s_q.cnt == '0) |=> s_q.irq) else $error("no interrupt on zero pass");
  COV_GATE_DONE: cover property (@(posedge clk) disable iff (rst)
    s_q.gs == uic_pkg::GS_MEAS ##[1:50] s_q.gs == uic_pkg::GS_IDLE);
endmodule : uic_channel

// *** hdl/uic_pkg.sv ***
package uic_pkg;
  // clock and timing
  localparam int CLK_HZ = 40_000_000;
  localparam int GATE_SHORT_MS = 100;
  localparam int GATE_MID_MS = 1000;
  localparam int GATE_LONG_MS = 10000;
  localparam int GATE_SHORT_CYC = CLK_HZ / 1000 * GATE_SHORT_MS;
  localparam int GATE_MID_CYC = CLK_HZ / 1000 * GATE_MID_MS;
  localparam int GATE_LONG_CYC = CLK_HZ / 1000 * GATE_LONG_MS;
  localparam int PERIOD_TICK_US = 25;
  localparam int PERIOD_TICK_CYC = CLK_HZ / 1_000_000 * PERIOD_TICK_US;
  // sizes
  localparam int NUM_UIN = 4;
  localparam int NUM_CNT = 3;
  localparam int WIDTH_SHORT = 16;
  localparam int WIDTH_LONG = 24;
  // parameter byte of each input
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_DIR_BIT = 3;
  localparam int CFG_FALL_BIT = 4;
  localparam int CFG_IRQ_BIT = 5;
  localparam int CFG_GSEL_LSB = 6;
  localparam logic [7:0] CFG_RESET = 8'h40;
  // counter control byte and run bit of the pin register
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_LOAD_LSB = 4;
  localparam int PINS_RUN_BIT = 8;
  // register byte offsets
  localparam logic [7:0] ADDR_CFG1 = 8'h00;
  localparam logic [7:0] ADDR_CFG2 = 8'h04;
  localparam logic [7:0] ADDR_CFG3 = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_CMP1 = 8'h10;
  localparam logic [7:0] ADDR_CMP2 = 8'h14;
  localparam logic [7:0] ADDR_CMP3 = 8'h18;
  localparam logic [7:0] ADDR_VAL1 = 8'h1c;
  localparam logic [7:0] ADDR_VAL2 = 8'h20;
  localparam logic [7:0] ADDR_VAL3 = 8'h24;
  localparam logic [7:0] ADDR_PINS = 8'h28;
  localparam logic [7:0] ADDR_ISTAT = 8'h2c;
  localparam logic [7:0] ADDR_ICLR = 8'h30;
  localparam logic [7:0] ADDR_IEN = 8'h34;
  // operating types
  typedef enum logic [2:0] {
    MODE_PLAIN = 3'h0,
    MODE_IRQ = 3'h1,
    MODE_COUNT = 3'h2,
    MODE_GATE = 3'h3,
    MODE_FREQ = 3'h4,
    MODE_PERIOD = 3'h5
  } uic_mode_type;
  typedef enum logic [1:0] {
    GSEL_SHORT = 2'h0,
    GSEL_MID = 2'h1,
    GSEL_LONG = 2'h2
  } uic_gsel_type;
  // gate measurement states
  typedef enum logic [1:0] {
    GS_IDLE = 2'b01,
    GS_MEAS = 2'b10
  } uic_gate_state_type;
endpackage : uic_pkg

// *** hdl/uic_top.sv ***
// Functional notes
// - the staged parameter set of all inputs is applied on every halted-to-running change.
// - an input set to interrupt type raises an interrupt on its chosen edge, rising by default.
// - plain counters are 16 bits on inputs 1 and 2 and 24 bits on input 3.
// - gate counting is 16 or 24 bits likewise, and frequency and period exist on input 3 only.
// - frequency and period results are always 24-bit values.
// - inputs 1 to 3 offer plain, interrupt, counter and gate types, input 3 also frequency and period.
// - each counter counts up or down as its direction bit says, up by default.
// - each counter steps only on its selected edge, rising by default.
// - with interrupts on, an up counter interrupts at its comparison value, a down one past zero.
// - period counting needs nothing beyond the chosen type, gate counting also needs its enable bit set.
// - a deactivated input is a plain digital input whose level can be read.
// - a deactivated input is sampled every enabled cycle through two synchroniser stages, and a read returns the second stage.
// - a counter takes a new start or comparison value only when its load bit is one.
// - a gate counter clears on gate rise, counts while high and publishes on gate fall.
// - before a first valid measurement the result reads as all ones of the counter width.
module uic_top #(
  parameter int FREQ_SHORT_CYC = uic_pkg::GATE_SHORT_CYC,
  parameter int FREQ_MID_CYC = uic_pkg::GATE_MID_CYC,
  parameter int FREQ_LONG_CYC = uic_pkg::GATE_LONG_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic RUN,
  input wire logic [3:0] UIN,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic IRQ
);
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic run_prev;
    logic running;
    logic apply;
    logic [2:0][7:0] pcfg;
    logic [2:0][7:0] acfg;
    logic [2:0] en;
    logic [2:0] load;
    logic [2:0][23:0] cmp;
    logic [2:0] stat;
    logic [2:0] ien;
    logic [31:0] rdata;
  } uic_top_st_type;

  uic_top_st_type s_q, s_d;
  logic [2:0][23:0] val_w;
  logic [2:0] ch_irq;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // counter channels
  for (genvar i = 0; i < uic_pkg::NUM_CNT; i++) begin : g_ch
    localparam int CW = (i == 2) ? uic_pkg::WIDTH_LONG : uic_pkg::WIDTH_SHORT;
    logic [CW-1:0] ch_val;
    uic_channel #(
      .W(CW),
      .HAS_FREQ(i == 2),
      .FREQ_SHORT_CYC(FREQ_SHORT_CYC),
      .FREQ_MID_CYC(FREQ_MID_CYC),
      .FREQ_LONG_CYC(FREQ_LONG_CYC),
      .TICK_CYC(uic_pkg::PERIOD_TICK_CYC)
    ) u_ch (
      .clk(CLK),
      .rst(RST),
      .ce(CE),
      .running(s_q.running),
      .apply(s_q.apply),
      .lvl(s_q.sync2[i]),
      .cfg(s_q.acfg[i]),
      .cnt_en(s_q.en[i]),
      .load(s_q.load[i]),
      .cmp_val(s_q.cmp[i][CW-1:0]),
      .value(ch_val),
      .irq(ch_irq[i])
    );
    assign val_w[i] = 24'(ch_val);
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file and control
  always_comb begin
    s_d = s_q;
    s_d.sync1 = UIN;
    s_d.sync2 = s_q.sync1;
    s_d.run_prev = RUN;
    s_d.running = RUN;
    s_d.apply = RUN && !s_q.run_prev;
    if (s_d.apply) begin
      s_d.acfg = s_q.pcfg;
    end
    s_d.load = '0;
    s_d.stat = s_q.stat | ch_irq;
    s_d.rdata = '0;
    if (WR) begin
      if (hit(ADDR, uic_pkg::ADDR_CFG1)) s_d.pcfg[0] = WDATA[7:0];
      if (hit(ADDR, uic_pkg::ADDR_CFG2)) s_d.pcfg[1] = WDATA[7:0];
      if (hit(ADDR, uic_pkg::ADDR_CFG3)) s_d.pcfg[2] = WDATA[7:0];
      if (hit(ADDR, uic_pkg::ADDR_CTRL)) begin
        s_d.en = WDATA[uic_pkg::CTRL_EN_LSB +: 3];
        s_d.load = WDATA[uic_pkg::CTRL_LOAD_LSB +: 3];
      end
      if (hit(ADDR, uic_pkg::ADDR_CMP1)) s_d.cmp[0] = {8'h00, WDATA[15:0]};
      if (hit(ADDR, uic_pkg::ADDR_CMP2)) s_d.cmp[1] = {8'h00, WDATA[15:0]};
      if (hit(ADDR, uic_pkg::ADDR_CMP3)) s_d.cmp[2] = WDATA[23:0];
      if (hit(ADDR, uic_pkg::ADDR_ICLR)) s_d.stat = (s_q.stat & ~WDATA[2:0]) | ch_irq;
      if (hit(ADDR, uic_pkg::ADDR_IEN)) s_d.ien = WDATA[2:0];
    end
    if (RD) begin
      case (ADDR)
        uic_pkg::ADDR_CFG1: s_d.rdata = {24'h000000, s_q.pcfg[0]};
        uic_pkg::ADDR_CFG2: s_d.rdata = {24'h000000, s_q.pcfg[1]};
        uic_pkg::ADDR_CFG3: s_d.rdata = {24'h000000, s_q.pcfg[2]};
        uic_pkg::ADDR_CTRL: s_d.rdata = {29'h0, s_q.en};
        uic_pkg::ADDR_CMP1: s_d.rdata = {8'h00, s_q.cmp[0]};
        uic_pkg::ADDR_CMP2: s_d.rdata = {8'h00, s_q.cmp[1]};
        uic_pkg::ADDR_CMP3: s_d.rdata = {8'h00, s_q.cmp[2]};
        uic_pkg::ADDR_VAL1: s_d.rdata = {8'h00, val_w[0]};
        uic_pkg::ADDR_VAL2: s_d.rdata = {8'h00, val_w[1]};
        uic_pkg::ADDR_VAL3: s_d.rdata = {8'h00, val_w[2]};
        // second synchroniser stage, refreshed every enabled cycle
        uic_pkg::ADDR_PINS: s_d.rdata = {23'h0, s_q.running, 4'h0, s_q.sync2};
        uic_pkg::ADDR_ISTAT: s_d.rdata = {29'h0, s_q.stat};
        uic_pkg::ADDR_IEN: s_d.rdata = {29'h0, s_q.ien};
        default: s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s_q <= '0;
      s_q.pcfg <= {3{uic_pkg::CFG_RESET}};
      s_q.acfg <= {3{uic_pkg::CFG_RESET}};
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  assign RDATA = s_q.rdata;
  assign IRQ = |(s_q.stat & s_q.ien);

  ////////////////////////////////////////////////////////////////////////////
  AST_APPLY: assert property (@(posedge CLK) disable iff (RST)
    (CE && RUN && !s_q.run_prev) |=> (s_q.apply && s_q.acfg == $past(s_q.pcfg)))
    else $error("parameter set not applied on start");
  AST_STICKY: assert property (@(posedge CLK) disable iff (RST)
    (CE && ch_irq[0]) |=> s_q.stat[0]) else $error("interrupt event lost");
  AST_PIN_READ: assert property (@(posedge CLK) disable iff (RST)
    (CE && RD && ADDR == uic_pkg::ADDR_PINS) |=> RDATA[3:0] == $past(s_q.sync2))
    else $error("pin level read mismatch");
  AST_RDATA_ONE: assert property (@(posedge CLK) disable iff (RST)
    (CE && !RD) |=> RDATA == '0) else $error("read data stands too long");
  COV_APPLY: cover property (@(posedge CLK) disable iff (RST) s_q.apply);
  COV_IRQ: cover property (@(posedge CLK) disable iff (RST) IRQ);
  COV_LOAD: cover property (@(posedge CLK) disable iff (RST) s_q.load != 3'h0);
endmodule : uic_top

// *** tb/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RST, CE, RUN, WR, RD, IRQ, go, fbusy;
  logic [3:0] UIN, flvl;
  logic [7:0] ADDR, fn, fhi;
  logic [1:0] fch;
  logic [31:0] WDATA, RDATA, d;
  int fails, tests_run, k, n, h, g;
  uic_top #(.FREQ_SHORT_CYC(100), .FREQ_MID_CYC(200), .FREQ_LONG_CYC(400)) uut (
    .CLK(CLK), .RST(RST), .CE(CE), .RUN(RUN), .UIN(UIN), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ));
  uic_field field (.clk(CLK), .go(go), .ch(fch), .npulse(fn), .hi_cyc(fhi), .lvl(flvl),
    .uin(UIN), .busy(fbusy));
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // report
  task automatic test_done;
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    tests_run++;
    if (v !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, v);
    end
  endtask : chk
  // measurements whose phase against the pulses may shift one count
  task automatic chk_near(input string nm, input int e, input logic [31:0] v);
    tests_run++;
    if ((^v === 1'bx) || v > 32'(e + 1) || v + 1 < 32'(e)) begin
      fails++;
      $display("ERROR %s expected %0d seen %h", nm, e, v);
    end
  endtask : chk_near
  ////////////////////////////////////////////////////////////////////////////////
  // register bus and field drivers
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, e, d);
  endtask : rc
  task automatic restart;
    @(posedge CLK);
    RUN <= 1'b0;
    repeat (3) @(posedge CLK);
    RUN <= 1'b1;
    repeat (5) @(posedge CLK);
  endtask : restart
  task automatic settle;
    repeat (5) @(posedge CLK);
  endtask : settle
  task automatic pulse(input logic [1:0] c, input int np, input int hi);
    @(posedge CLK);
    fch <= c;
    fn <= 8'(np);
    fhi <= 8'(hi);
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
    #1;
    for (k = 0; k < 4000 && fbusy; k++) begin
      @(posedge CLK);
      #1;
    end
    if (fbusy) begin
      fails++;
      $display("ERROR pulse train expected done seen busy");
      test_done();
    end
    settle();
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  initial begin
    RST = 1'b1;
    CE = 1'b1;
    RUN = 1'b0;
    ADDR = 8'h00;
    WDATA = 32'h0;
    WR = 1'b0;
    RD = 1'b0;
    go = 1'b0;
    fch = 2'h0;
    fn = 8'h00;
    fhi = 8'h01;
    flvl = 4'h0;
    fails = 0;
    tests_run = 0;
    k = $urandom(24995);
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    #1;
    chk("IRQ", 32'h0, {31'h0, IRQ});
    rc(uic_pkg::ADDR_VAL1, 32'hffff, "VAL1 reset");
    rc(uic_pkg::ADDR_VAL3, 32'hffffff, "VAL3 reset");
    for (g = 0; g < 3; g++) rc(uic_pkg::ADDR_CFG1 + 8'(4 * g), 32'h40, "CFG");
    rc(8'hfc, 32'h0, "unmapped");
    flvl <= 4'($urandom);
    settle();
    rc(uic_pkg::ADDR_PINS, {28'h0, flvl}, "PINS");
    flvl <= 4'h0;
    // up counter on input 1, down counter on falling edge on input 2
    n = 3 + $urandom % 6;
    wr(uic_pkg::ADDR_CFG1, 32'h22);
    wr(uic_pkg::ADDR_CFG2, 32'h3a);
    wr(uic_pkg::ADDR_CMP1, 32'(n));
    wr(uic_pkg::ADDR_CMP2, 32'(n));
    wr(uic_pkg::ADDR_IEN, 32'h7);
    wr(uic_pkg::ADDR_CTRL, 32'h33);
    restart();
    rc(uic_pkg::ADDR_PINS, 32'h100, "PINS run");
    pulse(2'd0, n - 1, 3);
    rc(uic_pkg::ADDR_VAL1, 32'(n - 1), "VAL1");
    rc(uic_pkg::ADDR_ISTAT, 32'h0, "ISTAT");
    pulse(2'd0, 1, 3);
    rc(uic_pkg::ADDR_VAL1, 32'(n), "VAL1");
    rc(uic_pkg::ADDR_ISTAT, 32'h1, "ISTAT");
    chk("IRQ", 32'h1, {31'h0, IRQ});
    pulse(2'd1, n - 1, 3);
    rc(uic_pkg::ADDR_VAL2, 32'h1, "VAL2");
    flvl <= 4'h2;
    settle();
    rc(uic_pkg::ADDR_VAL2, 32'h1, "VAL2 rise");
    flvl <= 4'h0;
    settle();
    rc(uic_pkg::ADDR_VAL2, 32'h0, "VAL2 fall");
    rc(uic_pkg::ADDR_ISTAT, 32'h1, "ISTAT");
    pulse(2'd1, 1, 3);
    rc(uic_pkg::ADDR_VAL2, 32'hffff, "VAL2 wrap");
    rc(uic_pkg::ADDR_ISTAT, 32'h3, "ISTAT");
    wr(uic_pkg::ADDR_ICLR, 32'h1);
    rc(uic_pkg::ADDR_ISTAT, 32'h2, "ISTAT clr");
    rc(uic_pkg::ADDR_ICLR, 32'h0, "ICLR");
    wr(uic_pkg::ADDR_IEN, 32'h1);
    #1;
    chk("IRQ masked", 32'h0, {31'h0, IRQ});
    wr(uic_pkg::ADDR_ICLR, 32'h2);
    wr(uic_pkg::ADDR_IEN, 32'h7);
    // new compare without load bit keeps the old start value
    wr(uic_pkg::ADDR_CMP2, 32'h5);
    wr(uic_pkg::ADDR_CTRL, 32'h3);
    restart();
    pulse(2'd1, 1, 3);
    rc(uic_pkg::ADDR_VAL2, 32'(n - 1), "VAL2 reload");
    // interrupt input 3: staged while running, live after restart
    wr(uic_pkg::ADDR_CFG3, 32'h01);
    pulse(2'd2, 1, 3);
    rc(uic_pkg::ADDR_ISTAT, 32'h0, "ISTAT staged");
    restart();
    pulse(2'd2, 1, 3);
    rc(uic_pkg::ADDR_ISTAT, 32'h4, "ISTAT irq");
    chk("IRQ", 32'h1, {31'h0, IRQ});
    wr(uic_pkg::ADDR_ICLR, 32'h4);
    wr(uic_pkg::ADDR_CFG3, 32'h11);
    restart();
    flvl <= 4'h4;
    settle();
    rc(uic_pkg::ADDR_ISTAT, 32'h0, "ISTAT rise");
    flvl <= 4'h0;
    settle();
    rc(uic_pkg::ADDR_ISTAT, 32'h4, "ISTAT fall");
    wr(uic_pkg::ADDR_ICLR, 32'h4);
    // gate counting on inputs 1 and 3
    wr(uic_pkg::ADDR_CFG1, 32'h03);
    wr(uic_pkg::ADDR_CFG3, 32'h23);
    wr(uic_pkg::ADDR_CTRL, 32'h7);
    restart();
    rc(uic_pkg::ADDR_VAL3, 32'hffffff, "VAL3 none");
    h = 20 + $urandom % 100;
    pulse(2'd2, 1, h);
    rc(uic_pkg::ADDR_VAL1, 32'hffff, "VAL1 none");
    rc(uic_pkg::ADDR_ISTAT, 32'h4, "ISTAT gate");
    rd(uic_pkg::ADDR_VAL3);
    chk_near("VAL3 gate", h, d);
    rc(uic_pkg::ADDR_VAL3, d, "VAL3 hold");
    wr(uic_pkg::ADDR_ICLR, 32'h4);
    // frequency on input 3 for every gate time
    for (g = 0; g < 3; g++) begin
      wr(uic_pkg::ADDR_CFG3, 32'(4 + (g << 6)));
      restart();
      rc(uic_pkg::ADDR_VAL3, 32'hffffff, "VAL3 freq none");
      pulse(2'd2, (100 << g) * 3 / 10, 5);
      rd(uic_pkg::ADDR_VAL3);
      chk_near("VAL3 freq", (100 << g) / 10, d);
      rc(uic_pkg::ADDR_VAL3, d, "VAL3 hold");
    end
    // clock enable low freezes the pin synchronisers
    @(posedge CLK);
    CE <= 1'b0;
    flvl <= 4'h8;
    settle();
    CE <= 1'b1;
    rc(uic_pkg::ADDR_PINS, 32'h100, "PINS frozen");
    test_done();
  end
endmodule : tb

// *** tb/uic_field.sv ***
module uic_field (
  input wire logic clk,
  input wire logic go,
  input wire logic [1:0] ch,
  input wire logic [7:0] npulse,
  input wire logic [7:0] hi_cyc,
  input wire logic [3:0] lvl,
  output logic [3:0] uin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int k = 0;
  logic act = 1'b0;
  assign busy = act;
  ////////////////////////////////////////////////////////////////////////////////
  // pulse train on one pin: npulse periods, hi_cyc high then hi_cyc low
  always @(posedge clk) begin
    if (go) begin
      k <= 0;
      act <= 1'b1;
    end else if (act) begin
      k <= k + 1;
      if (k == 2 * int'(npulse) * int'(hi_cyc) - 1) begin
        act <= 1'b0;
      end
    end
  end
  // other pins stay at their static field level
  always_comb begin
    uin = lvl;
    if (busy && (k / int'(hi_cyc)) % 2 == 0) begin
      uin[ch] = ~lvl[ch];
    end
  end
endmodule : uic_field
